// *** dsc_defs.svh ***
/*
 Constants of the device security control block: register offsets,
 field positions, reset values and address ranges.
 Assumes byte addressing on the register bus and a 23-bit global map.
*/
`ifndef DSC_DEFS_SVH
`define DSC_DEFS_SVH
`define DSC_OFS_CTRL 4'h0
`define DSC_OFS_STATUS 4'h4
`define DSC_CTRL_FLASH_MAP 0
`define DSC_CTRL_EEPROM_MAP 1
`define DSC_CTRL_TRACE 2
`define DSC_CTRL_EXPAND 3
`define DSC_CTRL_RESET 8'h03
`define DSC_ST_UNSECURE_STATUS_BIT 0
`define DSC_ST_DBG_EN 1
`define DSC_ST_BC_BUSY 2
`define DSC_ST_SECURE 3
`define DSC_ST_SECREQ 4
`define DSC_ST_FIELD_LO 5
`define DSC_SEC_OPEN 2'h2
`define DSC_SECFW_LO 23'h7FFF80
`define DSC_SECFW_HI 23'h7FFFFF
`define DSC_STDFW_LO 23'h7FFF00
`define DSC_REG_MASK 23'h0007FF
`endif

// *** dsc_pkg.sv ***
/*
 Types of the device security control block.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package dsc_pkg;
   typedef enum logic [2:0] {
      MODE_NS, MODE_SS, MODE_NX, MODE_ES, MODE_EX, MODE_ST
   } dsc_mode_type;
   typedef enum logic [2:0] {
      BC_IDLE, BC_FLASH, BC_EEPROM, BC_PASS, BC_LOOP, BC_DONE
   } dsc_bc_type;
   typedef struct packed {
      logic valid;
      logic global;
      logic [22:0] addr;
   } dsc_dbg_req_type;
   typedef struct packed {
      logic valid;
      logic [22:0] addr;
   } dsc_dbg_out_type;
   typedef struct packed {
      logic valid;
      logic eeprom;
   } dsc_nvm_cmd_type;
endpackage : dsc_pkg
`default_nettype wire

// *** dsc_security.sv ***
/*
 Device security control: effective secure state, map gating, debug
 access filtering, trace and co-processor gating, blank-check sequencer
 and an Avalon-MM register slave with one wait state.
 Assumes all inputs synchronous to CLOCK; NVM_DONE is a one-cycle pulse.
*/
// The Avalon-MM slave port and the register addresses were chosen for this implementation.
`include "dsc_defs.svh"
`default_nettype none
module dsc_security
   import dsc_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire logic CE,
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic [1:0] SECURITY_FIELD,
   input wire dsc_mode_type MODE_PINS,
   input wire logic FW_ACTIVE,
   input wire logic [22:0] CPU_ADDR,
   output logic FLASH_SEL,
   output logic EEPROM_SEL,
   output logic SECFW_SEL,
   output logic STDFW_SEL,
   input wire dsc_dbg_req_type DBG_REQ,
   output dsc_dbg_out_type DBG_GRANT,
   output logic DBG_REJECT,
   output logic DBG_REGS_EN,
   output logic DBG_CMD_BLOCK,
   output dsc_nvm_cmd_type NVM_CMD,
   input wire logic NVM_DONE,
   input wire logic NVM_BLANK,
   output logic FW_JUMP_STD,
   output logic FW_LOOP,
   output logic TRACE_BUF_EN,
   input wire logic COPROC_WR,
   output logic COPROC_WR_EN,
   input wire logic [15:0] COPROC_RDATA,
   output logic [15:0] COPROC_RDATA_Q,
   input wire logic COPROC_STEP,
   output logic COPROC_STEP_EN,
   output logic SECURE
);

   // state caught after reset
   logic latched_r;
   logic secreq_r;
   logic [1:0] field_r;
   dsc_mode_type mode_r;
   dsc_mode_type mode_nxt;
   // software and firmware state
   logic [7:0] ctrl_r;
   logic unsecure_r;
   logic unsecure_nxt;
   logic dbg_en_r;
   logic dbg_en_nxt;
   logic secfw_map_r;
   dsc_bc_type bc_r;
   dsc_bc_type bc_nxt;
   logic jump_r;
   // bus
   logic ack_r;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;
   dsc_dbg_out_type grant_r;
   logic reject_r;
   logic [15:0] cop_rdata_r;

   // effective security
   wire secure = secreq_r & ~unsecure_r;
   wire expanded = (mode_r == MODE_NX) | (mode_r == MODE_ES) |
                   (mode_r == MODE_EX) | (mode_r == MODE_ST);
   wire sec_expanded = secure & expanded;
   wire field_secreq = (SECURITY_FIELD != `DSC_SEC_OPEN);
   wire bc_busy = (bc_r == BC_FLASH) | (bc_r == BC_EEPROM);
   wire ss_fw_write = FW_ACTIVE & (mode_r == MODE_SS);

   // register decode
   wire bus_req = AVS_READ | AVS_WRITE;
   wire take = bus_req & ~ack_r;
   // writes land at the edge that sees waitrequest low
   wire accept = bus_req & ack_r;
   wire sel_ctrl = (AVS_ADDRESS == `DSC_OFS_CTRL);
   wire sel_stat = (AVS_ADDRESS == `DSC_OFS_STATUS);
   wire wr_lane0 = accept & AVS_WRITE & AVS_BYTEENABLE[0];
   wire wr_ctrl = wr_lane0 & sel_ctrl;
   wire wr_stat = wr_lane0 & sel_stat & ss_fw_write;
   wire bc_pass = (bc_r == BC_EEPROM) & NVM_DONE & NVM_BLANK;
   wire bc_fail = bc_busy & NVM_DONE & ~NVM_BLANK;

   // map enables read back forced low when secured expanded
   wire flash_map = ctrl_r[`DSC_CTRL_FLASH_MAP] & ~sec_expanded;
   wire eeprom_map = ctrl_r[`DSC_CTRL_EEPROM_MAP] & ~sec_expanded;
   wire [7:0] ctrl_view = {ctrl_r[7:2], eeprom_map, flash_map};
   wire [7:0] stat_view = {1'b0, field_r, secreq_r, secure, bc_busy,
                           dbg_en_r, unsecure_r};

   // address decode
   wire in_secfw = (CPU_ADDR >= `DSC_SECFW_LO) &
                   (CPU_ADDR <= `DSC_SECFW_HI);
   wire in_stdfw = (CPU_ADDR >= `DSC_STDFW_LO) &
                   (CPU_ADDR <= `DSC_SECFW_HI);
   wire fw_space = in_stdfw;
   wire is_reg = ((DBG_REQ.addr & ~`DSC_REG_MASK) == 23'h000000);

   assign SECURE = secure;
   assign SECFW_SEL = secfw_map_r & in_secfw;
   assign STDFW_SEL = in_stdfw & ~SECFW_SEL & (mode_r == MODE_SS);
   assign FLASH_SEL = flash_map & ~sec_expanded & ~fw_space;
   assign EEPROM_SEL = eeprom_map & ~sec_expanded & ~fw_space;
   assign DBG_REGS_EN = ~secure;
   assign DBG_CMD_BLOCK = bc_busy;
   assign NVM_CMD.valid = bc_busy;
   assign NVM_CMD.eeprom = (bc_r == BC_EEPROM);
   assign FW_LOOP = (bc_r == BC_LOOP);
   assign FW_JUMP_STD = jump_r;
   assign TRACE_BUF_EN = ctrl_r[`DSC_CTRL_TRACE] & ~secure;
   assign COPROC_WR_EN = COPROC_WR & ~secure;
   assign COPROC_STEP_EN = COPROC_STEP & ~secure;
   assign COPROC_RDATA_Q = cop_rdata_r;
   assign DBG_GRANT = grant_r;
   assign DBG_REJECT = reject_r;
   assign AVS_WAITREQUEST = bus_req & ~ack_r;
   assign AVS_READDATA = rdata_r;

   // readback select, unmapped addresses read zero
   always_comb begin
      rdata_nxt = 32'h00000000;
      if (sel_ctrl) begin
         rdata_nxt = {24'h000000, ctrl_view};
      end else if (sel_stat) begin
         rdata_nxt = {24'h000000, stat_view};
      end
   end

   // mode: software may move single chip into expanded
   always_comb begin
      mode_nxt = mode_r;
      if (!latched_r) begin
         mode_nxt = MODE_PINS;
      end else if (wr_ctrl && AVS_WRITEDATA[`DSC_CTRL_EXPAND]) begin
         if (mode_r == MODE_NS) begin
            mode_nxt = MODE_NX;
         end else if (mode_r == MODE_SS) begin
            mode_nxt = MODE_ES;
         end
      end
   end

   // set beats clear for hardware-set flags
   always_comb begin
      unsecure_nxt = unsecure_r;
      dbg_en_nxt = dbg_en_r;
      if (wr_stat) begin
         unsecure_nxt = AVS_WRITEDATA[`DSC_ST_UNSECURE_STATUS_BIT];
         dbg_en_nxt = AVS_WRITEDATA[`DSC_ST_DBG_EN];
      end
      if (bc_pass) begin
         unsecure_nxt = 1'b1;
      end
      if (bc_fail) begin
         dbg_en_nxt = 1'b1;
      end
   end

   // blank-check sequencer
   always_comb begin
      bc_nxt = bc_r;
      case (bc_r)
         BC_IDLE: begin
            if (!latched_r && field_secreq && MODE_PINS == MODE_SS) begin
               bc_nxt = BC_FLASH;
            end else if (!latched_r) begin
               bc_nxt = BC_DONE;
            end
         end
         BC_FLASH: begin
            if (NVM_DONE) begin
               bc_nxt = NVM_BLANK ? BC_EEPROM : BC_LOOP;
            end
         end
         BC_EEPROM: begin
            if (NVM_DONE) begin
               bc_nxt = NVM_BLANK ? BC_PASS : BC_LOOP;
            end
         end
         BC_PASS: bc_nxt = BC_DONE;
         BC_LOOP: bc_nxt = BC_LOOP;
         BC_DONE: bc_nxt = BC_DONE;
         default: bc_nxt = BC_DONE;
      endcase
   end

   // reset-time capture
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         latched_r <= 1'b0;
         secreq_r <= 1'b1;
         field_r <= 2'h0;
         mode_r <= MODE_NS;
      end else if (CE) begin
         latched_r <= 1'b1;
         mode_r <= mode_nxt;
         if (!latched_r) begin
            secreq_r <= field_secreq;
            field_r <= SECURITY_FIELD;
         end
      end
   end

   // security flags and firmware mapping
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         unsecure_r <= 1'b0;
         dbg_en_r <= 1'b0;
         secfw_map_r <= 1'b0;
         bc_r <= BC_IDLE;
         jump_r <= 1'b0;
      end else if (CE) begin
         unsecure_r <= unsecure_nxt;
         dbg_en_r <= dbg_en_nxt;
         bc_r <= bc_nxt;
         jump_r <= bc_pass;
         if (unsecure_r) begin
            secfw_map_r <= 1'b0;
         end else if (!latched_r) begin
            secfw_map_r <= field_secreq & (MODE_PINS == MODE_SS);
         end
      end
   end

   // control register and bus answer
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_r <= `DSC_CTRL_RESET;
         ack_r <= 1'b0;
         rdata_r <= 32'h00000000;
      end else if (CE) begin
         ack_r <= take;
         if (take && AVS_READ) begin
            rdata_r <= rdata_nxt;
         end
         if (wr_ctrl) begin
            ctrl_r <= {5'h00, AVS_WRITEDATA[2:0]};
         end
      end
   end

   // debug access filter and co-processor read path
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         grant_r <= '0;
         reject_r <= 1'b0;
         cop_rdata_r <= 16'h0000;
      end else if (CE) begin
         reject_r <= DBG_REQ.valid & (bc_busy | (secure & DBG_REQ.global));
         grant_r.valid <= DBG_REQ.valid & ~bc_busy &
                          ~(secure & DBG_REQ.global);
         if (secure && !is_reg) begin
            grant_r.addr <= DBG_REQ.addr & `DSC_REG_MASK;
         end else begin
            grant_r.addr <= DBG_REQ.addr;
         end
         cop_rdata_r <= secure ? 16'h0000 : COPROC_RDATA;
      end
   end

   // checks
   default clocking cb @(posedge CLOCK);
   endclocking
   default disable iff (!RESETN);

   sequence s_ee_pass;
      CE && bc_r == BC_EEPROM && NVM_DONE && NVM_BLANK;
   endsequence
   sequence s_pass_effect;
      unsecure_r && !secure && jump_r;
   endsequence
   sequence s_fail;
      CE && bc_busy && NVM_DONE && !NVM_BLANK;
   endsequence

   secure_state_a: assert property (
      SECURE == (secreq_r && !unsecure_r))
      else $error("secure state mismatch");
   map_forced_a: assert property (
      sec_expanded |-> !FLASH_SEL && !EEPROM_SEL &&
                        ctrl_view[1:0] == 2'h0)
      else $error("map enable not forced low");
   secfw_range_a: assert property (
      SECFW_SEL |-> CPU_ADDR >= `DSC_SECFW_LO &&
                    (secure || $rose(unsecure_r)))
      else $error("secure firmware outside its range");
   secfw_unmap_a: assert property (
      CE && unsecure_r |=> !secfw_map_r)
      else $error("secure firmware still mapped");
   dbg_redirect_a: assert property (
      CE && secure && DBG_REQ.valid && !DBG_REQ.global && !bc_busy |=>
      DBG_GRANT.valid && (DBG_GRANT.addr & ~`DSC_REG_MASK) == 23'h0)
      else $error("debug access not redirected");
   dbg_global_a: assert property (
      CE && secure && DBG_REQ.valid && DBG_REQ.global |=>
      DBG_REJECT && !DBG_GRANT.valid)
      else $error("global debug access passed");
   unsecure_status_bit_source_a: assert property (
      CE && !unsecure_r && latched_r ##1 unsecure_r |->
      $past(wr_stat) || $past(bc_pass))
      else $error("unsecure bit set by illegal source");
   bc_pass_a: assert property (
      s_ee_pass |=> s_pass_effect)
      else $error("blank check pass not applied");
   bc_fail_a: assert property (
      s_fail |=> dbg_en_r && !unsecure_r && FW_LOOP)
      else $error("blank check fail not applied");
   trace_gate_a: assert property (
      secure |-> !TRACE_BUF_EN && !COPROC_WR_EN && !COPROC_STEP_EN)
      else $error("trace or co-processor not gated");
   bc_block_a: assert property (
      bc_busy |-> DBG_CMD_BLOCK && NVM_CMD.valid)
      else $error("debug not blocked in blank check");
   secreq_hold_a: assert property (
      latched_r |=> $stable(secreq_r))
      else $error("security request changed");
   bus_ack_a: assert property (
      CE && take |=> !AVS_WAITREQUEST || !bus_req)
      else $error("bus answer late"); 

   // reset, firmware, debug and bus checks
   unsecure_status_bit_reset_a: assert property (
      !latched_r |-> !unsecure_r && !dbg_en_r && !jump_r)
      else $error("flags not cleared by reset");
   secreq_field_a: assert property (
      CE && !latched_r |=>
      secreq_r == ($past(SECURITY_FIELD) != `DSC_SEC_OPEN))
      else $error("security request not taken from field");
   mode_latch_a: assert property (
      CE && !latched_r |=> mode_r == $past(MODE_PINS))
      else $error("reset mode not latched");
   bc_start_a: assert property (
      CE && !latched_r && field_secreq && MODE_PINS == MODE_SS |=>
      NVM_CMD.valid && !NVM_CMD.eeprom && secfw_map_r)
      else $error("blank check not started");
   nvm_order_a: assert property (
      CE && bc_r == BC_FLASH && NVM_DONE && NVM_BLANK |=>
      NVM_CMD.valid && NVM_CMD.eeprom)
      else $error("eeprom check not issued after flash");
   jump_pulse_a: assert property (
      CE && FW_JUMP_STD |=> !FW_JUMP_STD)
      else $error("jump pulse longer than one cycle");
   loop_hold_a: assert property (
      FW_LOOP |=> FW_LOOP)
      else $error("firmware loop left before reset");
   grant_plain_a: assert property (
      CE && !secure && DBG_REQ.valid && !bc_busy |=>
      DBG_GRANT.valid && DBG_GRANT.addr == $past(DBG_REQ.addr))
      else $error("unsecured debug access altered");
   dbg_busy_a: assert property (
      CE && bc_busy && DBG_REQ.valid |=> DBG_REJECT && !DBG_GRANT.valid)
      else $error("debug access passed during blank check");
   cop_read_a: assert property (
      CE && secure |=> COPROC_RDATA_Q == 16'h0000)
      else $error("co-processor data visible while secured");
   stat_guard_a: assert property (
      CE && AVS_WRITE && !ss_fw_write && !bc_pass |=>
      unsecure_r == $past(unsecure_r))
      else $error("unsecure bit written from illegal source");
   ctrl_write_a: assert property (
      CE && wr_ctrl |=> ctrl_r[2:0] == $past(AVS_WRITEDATA[2:0]))
      else $error("control write lost");
   read_zero_a: assert property (
      CE && take && AVS_READ && !sel_ctrl && !sel_stat |=>
      AVS_READDATA == 32'h00000000)
      else $error("unmapped read not zero");
endmodule : dsc_security
`default_nettype wire

// *** dsc_nvm_model.sv ***
/*
 Behavioural model of the flash and EEPROM command machines seen by the
 blank-check sequencer. Assumes the bench sets the erased state of each
 array, standing in for the debug host's own erase.
*/
`default_nettype none
module dsc_nvm_model
   import dsc_pkg::*;
#(
   parameter int LATENCY = 3
)
(
   input wire logic CLOCK,
   input wire logic RESETN,
   input wire dsc_nvm_cmd_type NVM_CMD,
   input wire logic FLASH_BLANK,
   input wire logic EEPROM_BLANK,
   output logic NVM_DONE,
   output logic NVM_BLANK
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] cnt_r;
   logic done_r;
   logic blank_r;
   wire logic ready = NVM_CMD.valid && !done_r && (cnt_r == 4'(LATENCY));
   wire logic busy = NVM_CMD.valid && !ready && !done_r;
   // erased state is owned by the host, never changed here
   wire logic result = NVM_CMD.eeprom ? EEPROM_BLANK : FLASH_BLANK;
   always_ff @(posedge CLOCK or negedge RESETN) begin
      if (!RESETN) begin
         cnt_r <= 4'h0;
         done_r <= 1'b0;
         blank_r <= 1'b0;
      end else begin
         done_r <= ready;
         cnt_r <= busy ? cnt_r + 4'h1 : 4'h0;
         // result line toggles outside the done pulse
         blank_r <= ready ? result : !blank_r;
      end
   end
   assign NVM_DONE = done_r;
   assign NVM_BLANK = blank_r;
endmodule : dsc_nvm_model
`default_nettype wire

// *** dsc_security_bench.sv ***
/*
 Self-checking bench of the device security control block.
 Assumes the NVM model answers blank checks; CE and byte enables tied high.
*/
`include "dsc_defs.svh"
`default_nettype none
module dsc_security_bench
   import dsc_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;
   logic clock, resetn, avs_read, avs_write, avs_waitrequest;
   logic [3:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, q;
   logic [1:0] security_field;
   dsc_mode_type mode_pins;
   logic fw_active, flash_sel, eeprom_sel, secfw_sel, stdfw_sel;
   logic [22:0] cpu_addr;
   dsc_dbg_req_type dbg_req;
   dsc_dbg_out_type dbg_grant;
   logic dbg_reject, dbg_regs_en, dbg_cmd_block, nvm_done, nvm_blank;
   dsc_nvm_cmd_type nvm_cmd;
   logic fw_jump_std, fw_loop, trace_buf_en, coproc_wr, coproc_wr_en;
   logic coproc_step, coproc_step_en, secure, fl_blank, ee_blank;
   logic [15:0] coproc_rdata, coproc_rdata_q;
   int mismatches, checks_done;

   dsc_security u_dsc_security (.CLOCK(clock), .RESETN(resetn), .CE(1'b1),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write),
      .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(4'hF),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
      .SECURITY_FIELD(security_field), .MODE_PINS(mode_pins),
      .FW_ACTIVE(fw_active), .CPU_ADDR(cpu_addr), .FLASH_SEL(flash_sel),
      .EEPROM_SEL(eeprom_sel), .SECFW_SEL(secfw_sel), .STDFW_SEL(stdfw_sel),
      .DBG_REQ(dbg_req), .DBG_GRANT(dbg_grant), .DBG_REJECT(dbg_reject),
      .DBG_REGS_EN(dbg_regs_en), .DBG_CMD_BLOCK(dbg_cmd_block),
      .NVM_CMD(nvm_cmd), .NVM_DONE(nvm_done), .NVM_BLANK(nvm_blank),
      .FW_JUMP_STD(fw_jump_std), .FW_LOOP(fw_loop),
      .TRACE_BUF_EN(trace_buf_en), .COPROC_WR(coproc_wr),
      .COPROC_WR_EN(coproc_wr_en), .COPROC_RDATA(coproc_rdata),
      .COPROC_RDATA_Q(coproc_rdata_q), .COPROC_STEP(coproc_step),
      .COPROC_STEP_EN(coproc_step_en), .SECURE(secure));

   dsc_nvm_model u_dsc_nvm_model (.CLOCK(clock), .RESETN(resetn),
      .NVM_CMD(nvm_cmd), .FLASH_BLANK(fl_blank), .EEPROM_BLANK(ee_blank),
      .NVM_DONE(nvm_done), .NVM_BLANK(nvm_blank));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic end_sim;
      if (mismatches == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim

   task automatic hang;
      mismatches++;
      end_sim();
   endtask : hang

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask : step

   // one access; entered and left on a rising edge
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      logic wq;
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= {24'h000000, d};
      for (n = 0; n < 20; n++) begin
         #7;
         wq = avs_waitrequest;
         q = avs_readdata;
         @(posedge clock);
         if (wq === 1'b0) break;
      end
      if (n == 20) hang();
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
   endtask : bus

   task automatic rdchk(input logic [3:0] a, input logic [31:0] m,
                        input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(q & m, e);
   endtask : rdchk

   task automatic boot(input dsc_mode_type m, input logic [1:0] f,
                       input logic fb, input logic eb);
      int n;
      logic bc, ok, jump;
      bc = (m == MODE_SS) && (f != `DSC_SEC_OPEN);
      ok = fb && eb;
      jump = 1'b0;
      resetn <= 1'b0;
      mode_pins <= m;
      security_field <= f;
      fl_blank <= fb;
      ee_blank <= eb;
      cpu_addr <= `DSC_SECFW_LO;
      step(8);
      #1 chk(secure, 1'b1);
      step(1);
      resetn <= 1'b1;
      step(2);
      dbg_req <= '{1'b1, 1'b0, 23'h000010};
      step(1);
      dbg_req.valid <= 1'b0;
      #1 chk(dbg_cmd_block, bc);
      chk(dbg_reject, bc);
      chk(secfw_sel, bc);
      chk(nvm_cmd, {bc, 1'b0});
      for (n = 0; n < 100; n++) begin
         step(1);
         #1 if (fw_jump_std === 1'b1) jump = 1'b1;
         if (dbg_cmd_block !== 1'b1) break;
      end
      if (n == 100) hang();
      step(2);
      #1 chk(jump, bc && ok);
      chk(fw_loop, bc && !ok);
      chk(secfw_sel, bc && !ok);
      chk(stdfw_sel, (m == MODE_SS) && !(bc && !ok));
      chk(secure, (f != `DSC_SEC_OPEN) && !(bc && ok));
      step(1);
   endtask : boot

   task automatic gates(input logic sec);
      rdchk(4'h0, 32'hFF, {24'h0, `DSC_CTRL_RESET});
      rdchk(4'h4, 32'h1F, {27'h0, sec, sec, 3'h0});
      rdchk(4'h8, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 4'h0, 8'h07);
      coproc_wr <= 1'b1;
      coproc_step <= 1'b1;
      coproc_rdata <= 16'hA5C3;
      dbg_req <= '{1'b1, 1'b1, `DSC_STDFW_LO};
      step(1);
      dbg_req <= '{1'b1, 1'b0, `DSC_STDFW_LO};
      #1 chk(trace_buf_en, !sec);
      chk(dbg_regs_en, !sec);
      chk(coproc_wr_en, !sec);
      chk(coproc_step_en, !sec);
      chk(dbg_reject, sec);
      chk(coproc_rdata_q, sec ? 16'h0000 : 16'hA5C3);
      step(1);
      dbg_req.valid <= 1'b0;
      #1 chk(dbg_grant, {1'b1, sec ? `DSC_STDFW_LO & `DSC_REG_MASK
                                   : `DSC_STDFW_LO});
      step(1);
      bus(1'b1, 4'h0, 8'h0F);
      rdchk(4'h0, 32'h3, {30'h0, !sec, !sec});
      for (int a = 0; a < 4; a++) begin
         cpu_addr <= 23'(a) << 21;
         step(1);
         #1 chk(flash_sel, !sec);
         chk(eeprom_sel, !sec);
      end
      step(1);
   endtask : gates

   initial begin
      resetn = 1'b0;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      security_field = 2'h0;
      mode_pins = MODE_NS;
      fw_active = 1'b0;
      cpu_addr = 23'h0;
      dbg_req = '0;
      coproc_wr = 1'b0;
      coproc_step = 1'b0;
      coproc_rdata = 16'h0;
      fl_blank = 1'b1;
      ee_blank = 1'b1;
      mismatches = 0;
      checks_done = 0;
      step(1);
      for (int f = 0; f < 4; f++) begin
         // ends on the open pattern so the next gates run unsecured
         boot(MODE_NS, 2'(f + 3), 1'b1, 1'b1);
      end
      gates(1'b0);
      boot(MODE_NS, 2'h1, 1'b1, 1'b1);
      gates(1'b1);
      security_field <= 2'h2;
      step(2);
      #1 chk(secure, 1'b1);
      step(1);
      boot(MODE_SS, 2'h0, 1'b1, 1'b1);
      boot(MODE_SS, 2'h2, 1'b0, 1'b0);
      boot(MODE_SS, 2'h1, 1'b1, 1'b0);
      boot(MODE_SS, 2'h3, 1'b0, 1'b1);
      rdchk(4'h4, 32'h0B, 32'h0A);
      cpu_addr <= 23'h7FFF7F;
      step(1);
      #1 chk(secfw_sel, 1'b0);
      chk(stdfw_sel, 1'b1);
      step(1);
      cpu_addr <= `DSC_SECFW_HI;
      bus(1'b1, 4'h4, 8'h01);
      #1 chk(secfw_sel, 1'b1);
      chk(stdfw_sel, 1'b0);
      chk(secure, 1'b1);
      step(1);
      fw_active <= 1'b1;
      step(1);
      bus(1'b1, 4'h4, 8'h03);
      step(1);
      #1 chk(secfw_sel, 1'b0);
      chk(stdfw_sel, 1'b1);
      chk(secure, 1'b0);
      step(1);
      rdchk(4'h4, 32'h09, 32'h01);
      boot(MODE_SS, 2'h3, 1'b0, 1'b1);
      end_sim();
   end
endmodule : dsc_security_bench
`default_nettype wire
